// ### design/enh_regs_pkg.sv
// Constants for the offset calibration and enhancement register bank
package enh_regs_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_ANALOG_OFFSET = 10'h068;
	localparam logic [9:0] IDX_DAC_CAL       = 10'h069;
	localparam logic [9:0] IDX_PEAK_CAL      = 10'h06b;
	localparam logic [9:0] IDX_ENHANCE       = 10'h06c;
	localparam logic [9:0] IDX_LINE_CTRL     = 10'h070;
	localparam logic [9:0] IDX_STATUS        = 10'h071;
	localparam int         ADDR_W            = 12;

	// Reset values
	localparam logic [3:0] RST_ANALOG_OFFSET = 4'h0;
	localparam logic [7:0] RST_DAC_CAL       = 8'h00;
	localparam logic [3:0] RST_PEAK_CAL      = 4'h8;
	localparam logic [7:0] RST_ENHANCE       = 8'h00;
	localparam logic [2:0] RST_LIMIT         = 3'h0;

	// Enhancement enable bit positions
	localparam int ENH_LIMIT_BOOST = 7;
	localparam int ENH_FSK         = 6;
	localparam int ENH_SPEEDUP     = 5;
	localparam int ENH_VOLT_CLOSE  = 2;
	localparam int ENH_SQUELCH     = 1;
	localparam int ENH_HYST        = 0;
	localparam logic [7:0] ENH_WRITABLE = 8'he7;

	// Line control fields
	localparam int LC_RELAY   = 6;
	localparam int LC_LIMIT_H = 2;
	localparam int LC_LIMIT_L = 0;

	// Status fields
	localparam int ST_BOOST   = 0;
	localparam int ST_FAST    = 1;
	localparam int ST_LIMIT_L = 4;

	// Limit code meaning 41 mA, the top of the range
	localparam logic [2:0] LIMIT_41MA = 3'h7;

	// Indirect base of tone 1 parameter sets
	localparam logic [6:0] TONE1_FREQUENCY_COEFF_BASE = 7'h00;
	localparam logic [6:0] FSK_BASE  = 7'h45;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing
	localparam int SYS_CLK_HZ    = 100_000_000;
	localparam int TONE_HZ       = 8_000;
	localparam int FSK_TONE_HZ   = 24_000;
	localparam int BOOST_HOLD_US = 10_000;
	localparam int TONE_CYCLES   = SYS_CLK_HZ / TONE_HZ;
	localparam int FSK_CYCLES    = SYS_CLK_HZ / FSK_TONE_HZ;
	localparam int BOOST_CYCLES  = BOOST_HOLD_US * (SYS_CLK_HZ / 1_000_000);
	localparam int CNT_W         = 24;
endpackage

// ### design/rate_divider.sv
// Tick divider with two selectable periods
`timescale 1ns/100ps
`default_nettype none
module rate_divider #(
	parameter int SLOW  = 12500,
	parameter int FAST  = 4166,
	parameter int CNT_W = 24
) (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic fast,
	output logic      tick
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] last;

	// Terminal count for the selected rate
	assign last = fast ? CNT_W'(FAST - 1) : CNT_W'(SLOW - 1);

	// Count up one period, restart at the terminal count or on overshoot after a rate change
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			count <= '0;
			tick  <= 1'b0;
		end
		else if (count >= last)
		begin
			count <= '0;
			tick  <= 1'b1;
		end
		else
		begin
			count <= count + CNT_W'(1);
			tick  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### design/enh_regs.sv
// Offset calibration and enhancement register bank with AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
module enh_regs #(
	parameter int TONE_CYCLES  = enh_regs_pkg::TONE_CYCLES,
	parameter int FSK_CYCLES   = enh_regs_pkg::FSK_CYCLES,
	parameter int BOOST_CYCLES = enh_regs_pkg::BOOST_CYCLES
) (
	input  wire logic                            CLOCK,
	input  wire logic                            SRST,
	input  wire logic [enh_regs_pkg::ADDR_W-1:0] AWADDR,
	input  wire logic                            AWVALID,
	output logic                                 AWREADY,
	input  wire logic [31:0]                     WDATA,
	input  wire logic [3:0]                      WSTRB,
	input  wire logic                            WVALID,
	output logic                                 WREADY,
	output logic [1:0]                           BRESP,
	output logic                                 BVALID,
	input  wire logic                            BREADY,
	input  wire logic [enh_regs_pkg::ADDR_W-1:0] ARADDR,
	input  wire logic                            ARVALID,
	output logic                                 ARREADY,
	output logic [31:0]                          RDATA,
	output logic [1:0]                           RRESP,
	output logic                                 RVALID,
	input  wire logic                            RREADY,
	input  wire logic                            RING_ACTIVE,
	output logic [3:0]                           ANALOG_OFFSET,
	output logic [7:0]                           DAC_OFFSET_CAL_VALUE,
	output logic [3:0]                           PEAK_CURRENT_CAL_VALUE,
	output logic [2:0]                           CURRENT_LIMIT,
	output logic                                 TONE1_FAST,
	output logic                                 TONE1_TICK,
	output logic [6:0]                           TONE1_PARAM_BASE,
	output logic                                 CADENCE_FINE,
	output logic                                 CONVERTER_SPEEDUP,
	output logic                                 VOLTAGE_LOOP_CLOSURE,
	output logic                                 CLOSURE_HYSTERESIS,
	output logic                                 CONVERTER_SQUELCH
);
	logic [3:0]              offset_flags;
	logic [7:0]              dac_offset_cal_value;
	logic [3:0]              peak_current_cal_value;
	logic [7:0]              enhance;
	logic [2:0]              programmed_current_limit;
	logic                    relay_control_bit;
	logic [9:0]              wr_idx;
	logic [7:0]              wr_byte;
	logic                    wr_lane;
	logic                    have_aw;
	logic                    have_w;
	logic                    do_write;
	logic                    wr_hit;
	logic                    rd_hit;
	logic [7:0]              rd_byte;
	logic [9:0]              rd_idx;
	logic                    ring_last;
	logic                    burst_end;
	logic                    boost_active;
	logic [enh_regs_pkg::CNT_W-1:0] boost_count;
	logic                    fsk_mode;
	logic                    next_fast;

	assign do_write = have_aw && have_w && !BVALID;
	assign rd_idx   = ARADDR[enh_regs_pkg::ADDR_W-1:2];
	assign burst_end = ring_last && !RING_ACTIVE;
	assign fsk_mode  = enhance[enh_regs_pkg::ENH_FSK] && relay_control_bit;
	assign next_fast = fsk_mode;

	// Write address channel
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			AWREADY <= 1'b1;
			have_aw <= 1'b0;
			wr_idx  <= '0;
		end
		else if (AWVALID && AWREADY)
		begin
			AWREADY <= 1'b0;
			have_aw <= 1'b1;
			wr_idx  <= AWADDR[enh_regs_pkg::ADDR_W-1:2];
		end
		else if (do_write)
			have_aw <= 1'b0;
		else if (BVALID && BREADY)
			AWREADY <= 1'b1;
	end

	// Write data channel, low byte lane only carries register data
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			WREADY  <= 1'b1;
			have_w  <= 1'b0;
			wr_byte <= '0;
			wr_lane <= 1'b0;
		end
		else if (WVALID && WREADY)
		begin
			WREADY  <= 1'b0;
			have_w  <= 1'b1;
			wr_byte <= WDATA[7:0];
			wr_lane <= WSTRB[0];
		end
		else if (do_write)
			have_w <= 1'b0;
		else if (BVALID && BREADY)
			WREADY <= 1'b1;
	end

	// Write address decode
	always_comb
	begin
		if (wr_idx == enh_regs_pkg::IDX_ANALOG_OFFSET)
			wr_hit = 1'b1;
		else if (wr_idx == enh_regs_pkg::IDX_DAC_CAL)
			wr_hit = 1'b1;
		else if (wr_idx == enh_regs_pkg::IDX_PEAK_CAL)
			wr_hit = 1'b1;
		else if (wr_idx == enh_regs_pkg::IDX_ENHANCE)
			wr_hit = 1'b1;
		else if (wr_idx == enh_regs_pkg::IDX_LINE_CTRL)
			wr_hit = 1'b1;
		else if (wr_idx == enh_regs_pkg::IDX_STATUS)
			wr_hit = 1'b1;
		else
			wr_hit = 1'b0;
	end

	// Write response, unmapped address answers slave error
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			BVALID <= 1'b0;
			BRESP  <= enh_regs_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			BVALID <= 1'b1;
			BRESP  <= wr_hit ? enh_regs_pkg::RESP_OKAY : enh_regs_pkg::RESP_SLVERR;
		end
		else if (BVALID && BREADY)
			BVALID <= 1'b0;
	end

	// Register storage, reserved bits never stored
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			offset_flags             <= enh_regs_pkg::RST_ANALOG_OFFSET;
			dac_offset_cal_value     <= enh_regs_pkg::RST_DAC_CAL;
			peak_current_cal_value   <= enh_regs_pkg::RST_PEAK_CAL;
			enhance                  <= enh_regs_pkg::RST_ENHANCE;
			programmed_current_limit <= enh_regs_pkg::RST_LIMIT;
			relay_control_bit        <= 1'b0;
		end
		else if (do_write && wr_lane)
		begin
			if (wr_idx == enh_regs_pkg::IDX_ANALOG_OFFSET)
				offset_flags <= wr_byte[3:0];
			else if (wr_idx == enh_regs_pkg::IDX_DAC_CAL)
				dac_offset_cal_value <= wr_byte;
			else if (wr_idx == enh_regs_pkg::IDX_PEAK_CAL)
				peak_current_cal_value <= wr_byte[3:0];
			else if (wr_idx == enh_regs_pkg::IDX_ENHANCE)
				enhance <= wr_byte & enh_regs_pkg::ENH_WRITABLE;
			else if (wr_idx == enh_regs_pkg::IDX_LINE_CTRL)
			begin
				programmed_current_limit <= wr_byte[enh_regs_pkg::LC_LIMIT_H:enh_regs_pkg::LC_LIMIT_L];
				relay_control_bit        <= wr_byte[enh_regs_pkg::LC_RELAY];
			end
		end
	end

	// Read data mux
	always_comb
	begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		if (rd_idx == enh_regs_pkg::IDX_ANALOG_OFFSET)
			rd_byte = {4'h0, offset_flags};
		else if (rd_idx == enh_regs_pkg::IDX_DAC_CAL)
			rd_byte = dac_offset_cal_value;
		else if (rd_idx == enh_regs_pkg::IDX_PEAK_CAL)
			rd_byte = {4'h0, peak_current_cal_value};
		else if (rd_idx == enh_regs_pkg::IDX_ENHANCE)
			rd_byte = enhance;
		else if (rd_idx == enh_regs_pkg::IDX_LINE_CTRL)
		begin
			rd_byte[enh_regs_pkg::LC_LIMIT_H:enh_regs_pkg::LC_LIMIT_L] = programmed_current_limit;
			rd_byte[enh_regs_pkg::LC_RELAY] = relay_control_bit;
		end
		else if (rd_idx == enh_regs_pkg::IDX_STATUS)
		begin
			rd_byte[enh_regs_pkg::ST_BOOST] = boost_active;
			rd_byte[enh_regs_pkg::ST_FAST]  = TONE1_FAST;
			rd_byte[enh_regs_pkg::ST_LIMIT_L+:3] = CURRENT_LIMIT;
		end
		else
			rd_hit = 1'b0;
	end

	// Read channel, data answered one cycle after the address is taken
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			ARREADY <= 1'b1;
			RVALID  <= 1'b0;
			RDATA   <= '0;
			RRESP   <= enh_regs_pkg::RESP_OKAY;
		end
		else if (ARVALID && ARREADY)
		begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b1;
			RDATA   <= {24'h000000, rd_byte};
			RRESP   <= rd_hit ? enh_regs_pkg::RESP_OKAY : enh_regs_pkg::RESP_SLVERR;
		end
		else if (RVALID && RREADY)
		begin
			RVALID  <= 1'b0;
			ARREADY <= 1'b1;
		end
	end

	// Ring burst end detection and temporary limit boost
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			ring_last    <= 1'b0;
			boost_active <= 1'b0;
			boost_count  <= '0;
		end
		else
		begin
			ring_last <= RING_ACTIVE;
			if (!enhance[enh_regs_pkg::ENH_LIMIT_BOOST] || RING_ACTIVE)
				boost_active <= 1'b0;
			else if (burst_end)
			begin
				boost_active <= 1'b1;
				boost_count  <= enh_regs_pkg::CNT_W'(BOOST_CYCLES - 1);
			end
			else if (boost_count != '0)
				boost_count <= boost_count - enh_regs_pkg::CNT_W'(1);
			else
				boost_active <= 1'b0;
		end
	end

	// Outputs that steer the neighbouring line blocks
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			CURRENT_LIMIT        <= enh_regs_pkg::RST_LIMIT;
			TONE1_FAST           <= 1'b0;
			TONE1_PARAM_BASE     <= enh_regs_pkg::TONE1_FREQUENCY_COEFF_BASE;
			CADENCE_FINE         <= 1'b0;
			CONVERTER_SPEEDUP    <= 1'b0;
			VOLTAGE_LOOP_CLOSURE <= 1'b0;
			CLOSURE_HYSTERESIS   <= 1'b0;
			CONVERTER_SQUELCH    <= 1'b0;
		end
		else
		begin
			CURRENT_LIMIT        <= boost_active ? enh_regs_pkg::LIMIT_41MA : programmed_current_limit;
			TONE1_FAST           <= next_fast;
			TONE1_PARAM_BASE     <= next_fast ? enh_regs_pkg::FSK_BASE : enh_regs_pkg::TONE1_FREQUENCY_COEFF_BASE;
			CADENCE_FINE         <= next_fast;
			CONVERTER_SPEEDUP    <= enhance[enh_regs_pkg::ENH_SPEEDUP];
			VOLTAGE_LOOP_CLOSURE <= enhance[enh_regs_pkg::ENH_VOLT_CLOSE];
			CLOSURE_HYSTERESIS   <= enhance[enh_regs_pkg::ENH_HYST];
			CONVERTER_SQUELCH    <= enhance[enh_regs_pkg::ENH_SQUELCH];
		end
	end

	// Register contents mirrored to their consumers
	assign ANALOG_OFFSET          = offset_flags;
	assign DAC_OFFSET_CAL_VALUE   = dac_offset_cal_value;
	assign PEAK_CURRENT_CAL_VALUE = peak_current_cal_value;

	// Tone 1 sample tick, 8 kHz or 24 kHz
	rate_divider #(
		.SLOW  (TONE_CYCLES),
		.FAST  (FSK_CYCLES),
		.CNT_W (enh_regs_pkg::CNT_W)
	) tone_rate (
		.clock (CLOCK),
		.srst  (SRST),
		.fast  (TONE1_FAST),
		.tick  (TONE1_TICK)
	);

	// Named steps of a register write and read
	sequence wr_to(logic [9:0] idx);
		do_write && wr_lane && wr_idx == idx;
	endsequence
	sequence rd_take(logic [9:0] idx);
		ARVALID && ARREADY && rd_idx == idx;
	endsequence

	a_offset_upper_zero: assert property (@(posedge CLOCK) disable iff (SRST)
		rd_take(enh_regs_pkg::IDX_ANALOG_OFFSET) |=> RVALID && RDATA[31:4] == 28'h0)
		else $error("offset flag register upper bits not zero");

	a_dac_cal_write: assert property (@(posedge CLOCK) disable iff (SRST)
		wr_to(enh_regs_pkg::IDX_DAC_CAL) |=> DAC_OFFSET_CAL_VALUE == $past(wr_byte))
		else $error("dac offset result not stored");

	a_peak_cal_reset: assert property (@(posedge CLOCK)
		SRST |=> PEAK_CURRENT_CAL_VALUE == enh_regs_pkg::RST_PEAK_CAL)
		else $error("peak current result reset value wrong");

	a_limit_plain: assert property (@(posedge CLOCK) disable iff (SRST)
		!enhance[enh_regs_pkg::ENH_LIMIT_BOOST] ##1 !enhance[enh_regs_pkg::ENH_LIMIT_BOOST]
		|=> CURRENT_LIMIT == $past(programmed_current_limit))
		else $error("limit differs from programmed value");

	a_limit_boost: assert property (@(posedge CLOCK) disable iff (SRST)
		enhance[enh_regs_pkg::ENH_LIMIT_BOOST] && burst_end |=> ##1 CURRENT_LIMIT == enh_regs_pkg::LIMIT_41MA)
		else $error("limit not boosted after ring burst");

	a_fsk_rate_fast: assert property (@(posedge CLOCK) disable iff (SRST)
		fsk_mode |=> TONE1_FAST && CADENCE_FINE)
		else $error("tone not fast in enhanced fsk");

	a_fsk_param_set: assert property (@(posedge CLOCK) disable iff (SRST)
		fsk_mode |=> TONE1_PARAM_BASE == enh_regs_pkg::FSK_BASE)
		else $error("fsk parameter set not selected");

	a_cadence_fine: assert property (@(posedge CLOCK) disable iff (SRST)
		!fsk_mode |=> !CADENCE_FINE)
		else $error("cadence step not tied to tone rate");

	a_std_rate: assert property (@(posedge CLOCK) disable iff (SRST)
		!fsk_mode |=> !TONE1_FAST && TONE1_PARAM_BASE == enh_regs_pkg::TONE1_FREQUENCY_COEFF_BASE)
		else $error("standard tone mode not applied");

	a_speedup_follow: assert property (@(posedge CLOCK) disable iff (SRST)
		wr_to(enh_regs_pkg::IDX_ENHANCE) |=> ##1 CONVERTER_SPEEDUP == $past(wr_byte[enh_regs_pkg::ENH_SPEEDUP], 2))
		else $error("speedup select not applied");

	a_enh_reserved: assert property (@(posedge CLOCK) disable iff (SRST)
		rd_take(enh_regs_pkg::IDX_ENHANCE) |=> RDATA[4:3] == 2'h0)
		else $error("enhancement reserved bits not zero");
endmodule
`default_nettype wire

// ### test/test_enh_regs.sv
// Self-checking testbench for the enhancement register bank
`timescale 1ns/100ps
`default_nettype none
module test_enh_regs;
	localparam int TONE_P = 10;
	localparam int FSK_P = 4;
	localparam int BOOST_P = 20;
	localparam logic [1:0] OK = 2'h0;
	localparam logic [1:0] ERR = 2'h2;
	localparam logic [11:0] A_OFF = {enh_regs_pkg::IDX_ANALOG_OFFSET, 2'b00};
	localparam logic [11:0] A_DAC = {enh_regs_pkg::IDX_DAC_CAL, 2'b00};
	localparam logic [11:0] A_PEAK = {enh_regs_pkg::IDX_PEAK_CAL, 2'b00};
	localparam logic [11:0] A_ENH = {enh_regs_pkg::IDX_ENHANCE, 2'b00};
	localparam logic [11:0] A_LINE = {enh_regs_pkg::IDX_LINE_CTRL, 2'b00};
	localparam logic [11:0] A_STAT = {enh_regs_pkg::IDX_STATUS, 2'b00};
	localparam logic [11:0] A_BAD = 12'h1a8;
	logic        CLOCK = 1'b0;
	logic        SRST = 1'b1;
	logic [11:0] AWADDR = 12'h000;
	logic [11:0] ARADDR = 12'h000;
	logic [31:0] WDATA = 32'h0;
	logic [3:0]  WSTRB = 4'h0;
	logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
	logic        ARVALID = 1'b0, RREADY = 1'b0, RING_ACTIVE = 1'b0;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TONE1_FAST, TONE1_TICK;
	logic        CADENCE_FINE, CONVERTER_SPEEDUP, VOLTAGE_LOOP_CLOSURE;
	logic        CLOSURE_HYSTERESIS, CONVERTER_SQUELCH;
	logic [1:0]  BRESP, RRESP;
	logic [31:0] RDATA;
	logic [3:0]  ANALOG_OFFSET, PEAK_CURRENT_CAL_VALUE;
	logic [7:0]  DAC_OFFSET_CAL_VALUE;
	logic [2:0]  CURRENT_LIMIT;
	logic [6:0]  TONE1_PARAM_BASE;
	logic [31:0] rng = 32'h00000053;
	logic [1:0]  bq[$];
	logic [33:0] rq[$];
	int          mismatches = 0;
	int          checks = 0;

	enh_regs #(.TONE_CYCLES(TONE_P), .FSK_CYCLES(FSK_P), .BOOST_CYCLES(BOOST_P)) dut_u (
		.CLOCK, .SRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
		.BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
		.RREADY, .RING_ACTIVE, .ANALOG_OFFSET, .DAC_OFFSET_CAL_VALUE, .PEAK_CURRENT_CAL_VALUE,
		.CURRENT_LIMIT, .TONE1_FAST, .TONE1_TICK, .TONE1_PARAM_BASE, .CADENCE_FINE,
		.CONVERTER_SPEEDUP, .VOLTAGE_LOOP_CLOSURE, .CLOSURE_HYSTERESIS, .CONVERTER_SQUELCH
	);

	// Clock generation
	always #5 CLOCK = ~CLOCK;

	// Pseudo-random source
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task give_verdict;
		$display("Checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task check_bus(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: bus answer %h expected %h", $time, got, exp);
		end
	endtask

	task check_out(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: output %h expected %h", $time, got, exp);
		end
	endtask

	// Bus answers are matched against the oldest note
	always @(posedge CLOCK)
	begin
		if (BVALID && BREADY)
			check_bus({32'h0, BRESP}, {32'h0, bq.pop_front()});
		if (RVALID && RREADY)
			check_bus({RRESP, RDATA}, rq.pop_front());
	end

	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
		int n;
		logic [31:0] t;
		@(posedge CLOCK);
		t = rnd();
		bq.push_back(r);
		AWADDR <= a;
		WDATA <= {t[31:8], d};
		WSTRB <= s;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLOCK);
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
			if (BVALID)
				break;
		end
		BREADY <= 1'b0;
		if (n == 50)
		begin
			mismatches++;
			give_verdict();
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
		int n;
		@(posedge CLOCK);
		rq.push_back({r, 24'h0, d});
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLOCK);
			if (ARREADY)
				ARVALID <= 1'b0;
			if (RVALID)
				break;
		end
		RREADY <= 1'b0;
		if (n == 50)
		begin
			mismatches++;
			give_verdict();
		end
	endtask

	// Reset contents of the bank, unmapped place refused
	task chk_reset;
		rd(A_OFF, 8'h00, OK);
		rd(A_DAC, 8'h00, OK);
		rd(A_PEAK, 8'h08, OK);
		rd(A_ENH, 8'h00, OK);
		rd(A_BAD, 8'h00, ERR);
	endtask

	// Cycles from one tone tick to the next
	task automatic tick_gap(output int g);
		repeat (2)
		begin
			g = 0;
			do
			begin
				@(posedge CLOCK);
				g++;
			end
			while (!TONE1_TICK && g < 30);
		end
	endtask

	// Ring burst then count cycles at a limit code
	task automatic burst_count(input logic [2:0] v, output int c);
		@(posedge CLOCK);
		RING_ACTIVE <= 1'b1;
		repeat (3) @(posedge CLOCK);
		RING_ACTIVE <= 1'b0;
		c = 0;
		repeat (40)
		begin
			@(posedge CLOCK);
			if (CURRENT_LIMIT === v)
				c++;
		end
	endtask

	// Main sequence
	initial
	begin
		logic [31:0] v;
		logic [7:0] dv;
		logic f;
		logic rl;
		int g;
		repeat (4) @(posedge CLOCK);
		SRST <= 1'b0;
		chk_reset();
		$display("Test reset values done");
		for (int i = 0; i < 6; i++)
		begin
			v = rnd();
			dv = v[15:8];
			wr(A_OFF, v[7:0], 4'h1, OK);
			wr(A_DAC, dv, 4'hf, OK);
			wr(A_PEAK, v[23:16], 4'h1, OK);
			wr(A_ENH, v[31:24] & 8'h3f, 4'h1, OK);
			repeat (2) @(posedge CLOCK);
			check_out({4'h0, ANALOG_OFFSET}, {4'h0, v[3:0]});
			check_out(DAC_OFFSET_CAL_VALUE, dv);
			check_out({4'h0, PEAK_CURRENT_CAL_VALUE}, {4'h0, v[19:16]});
			check_out({7'h0, CONVERTER_SPEEDUP}, {7'h0, v[29]});
			check_out({7'h0, VOLTAGE_LOOP_CLOSURE}, {7'h0, v[26]});
			check_out({7'h0, CONVERTER_SQUELCH}, {7'h0, v[25]});
			check_out({7'h0, CLOSURE_HYSTERESIS}, {7'h0, v[24]});
			rd(A_OFF, v[7:0] & 8'h0f, OK);
			rd(A_PEAK, v[23:16] & 8'h0f, OK);
			rd(A_ENH, v[31:24] & 8'h27, OK);
		end
		wr(A_DAC, ~dv, 4'he, OK);
		wr(A_BAD, 8'hff, 4'h1, ERR);
		rd(A_DAC, dv, OK);
		$display("Test register access done");
		@(posedge CLOCK);
		SRST <= 1'b1;
		repeat (2) @(posedge CLOCK);
		SRST <= 1'b0;
		chk_reset();
		$display("Test second reset done");
		for (int k = 0; k < 4; k++)
		begin
			f = k[1];
			rl = k[0];
			wr(A_ENH, {1'b0, f, 6'h0}, 4'h1, OK);
			wr(A_LINE, {1'b0, rl, 6'h0}, 4'h1, OK);
			repeat (2) @(posedge CLOCK);
			check_out({7'h0, TONE1_FAST}, {7'h0, f & rl});
			check_out({1'b0, TONE1_PARAM_BASE}, (f & rl) ? 8'h45 : 8'h00);
			check_out({7'h0, CADENCE_FINE}, {7'h0, f & rl});
			tick_gap(g);
			check_out(8'(g), (f & rl) ? 8'(FSK_P) : 8'(TONE_P));
		end
		$display("Test tone rate done");
		wr(A_LINE, 8'h03, 4'h1, OK);
		wr(A_ENH, 8'h00, 4'h1, OK);
		burst_count(3'h3, g);
		check_out(8'(g), 8'd40);
		wr(A_ENH, 8'h80, 4'h1, OK);
		burst_count(3'h7, g);
		check_out(8'(g), 8'(BOOST_P));
		check_out({5'h0, CURRENT_LIMIT}, 8'h03);
		rd(A_STAT, 8'h30, OK);
		$display("Test current boost done");
		repeat (2) @(posedge CLOCK);
		give_verdict();
	end
endmodule
`default_nettype wire
